// ### verilog/tes_regs.svh
// Register map, field positions, reset values and timing constants
`ifndef TES_REGS_SVH
`define TES_REGS_SVH

`define TES_CLK_PERIOD_NS 4
`define TES_US_NS 1000
`define TES_US_CYCLES (`TES_US_NS / `TES_CLK_PERIOD_NS)
`define TES_US_CNT_W 8

`define TES_ADDR_W 8
`define TES_CTRL_OFFS 8'h00
`define TES_FRAMES_OFFS 8'h04
`define TES_INTEG_OFFS 8'h08
`define TES_READOUT_OFFS 8'h0C
`define TES_GLITCH_OFFS 8'h10
`define TES_LOCKOUT_OFFS 8'h14
`define TES_OFFSET_OFFS 8'h18
`define TES_SWTRIG_OFFS 8'h1C
`define TES_STATUS_OFFS 8'h20

`define TES_CTRL_SYNC_BIT 0
`define TES_CTRL_OVERLAP_BIT 1
`define TES_CTRL_ORIGIN_LSB 2
`define TES_CTRL_ORIGIN_MSB 3
`define TES_CTRL_EDGE_BIT 4
`define TES_CTRL_EXPSEL_BIT 5
`define TES_SWTRIG_BIT 0
`define TES_STAT_STATE_MSB 3
`define TES_STAT_DISCARD_BIT 4
`define TES_STAT_PENDING_BIT 5
`define TES_STAT_FRAMES_LSB 16
`define TES_CNT16_MSB 15
`define TES_TIME24_MSB 23

`define TES_FRAMES_RESET 16'h0001
`define TES_INTEG_RESET 24'h0003E8
`define TES_READOUT_RESET 24'h007A12
`define TES_GLITCH_RESET 16'h0000
`define TES_LOCKOUT_RESET 16'h0000
`define TES_OFFSET_RESET 24'h000000
`define TES_MIN_INTEG_US 24'h000024
`define TES_MAX_OFFSET_US 24'hF42400

`endif

// ### verilog/tes_pkg.sv
// Types shared by the trigger and exposure sequencer
package tes_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_OFFSET = 4'b0010,
        ST_EXPOSE = 4'b0100,
        ST_READ = 4'b1000
    } seq_state_e;

    typedef enum logic [1:0] {
        ORG_LINE_ONE = 2'h0,
        ORG_LINE_TWO = 2'h1,
        ORG_PULSE_GEN = 2'h2,
        ORG_SOFTWARE = 2'h3
    } origin_e;

    typedef struct packed {
        logic sync_enable;
        logic overlap_select;
        origin_e trigger_origin;
        logic edge_select;
        logic exposure_control_select;
        logic [15:0] frames_per_trigger;
        logic [23:0] integration_time;
        logic [23:0] frame_period_now;
        logic [15:0] glitch_reject_width;
        logic [15:0] lockout_time;
        logic [23:0] start_offset_time;
    } cfg_s;

endpackage

// ### verilog/us_countdown.sv
// Microsecond down-counter used for offset, exposure, readout and lockout
`timescale 1ns/1ps
module us_countdown #(
    parameter int WIDTH = 24
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic us_tick,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    output logic [WIDTH-1:0] remaining,
    output logic zero
);
    logic [WIDTH-1:0] count_reg;

    // Load wins over a tick in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_reg <= '0;
        else if (load)
            count_reg <= load_value;
        else if (us_tick && count_reg != '0)
            count_reg <= count_reg - 1'b1;
    end

    assign remaining = count_reg;
    assign zero = (count_reg == '0);
endmodule // us_countdown

// ### verilog/trigger_line_cond.sv
// Input line synchroniser with glitch rejection
`timescale 1ns/1ps
module trigger_line_cond #(
    parameter int WIDTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic us_tick,
    input wire logic line_pin,
    input wire logic [WIDTH-1:0] reject_width,
    output logic line_clean
);
    logic sync1_reg;
    logic sync2_reg;
    logic clean_reg;
    logic [WIDTH-1:0] hold_reg;

    // Two flops before anything looks at the pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= line_pin;
            sync2_reg <= sync1_reg;
        end
    end

    // New level must stay for the reject width before it is passed on
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clean_reg <= 1'b0;
            hold_reg <= '0;
        end
        else if (sync2_reg == clean_reg)
            hold_reg <= '0;
        else if (hold_reg >= reject_width)
        begin
            clean_reg <= sync2_reg;
            hold_reg <= '0;
        end
        else if (us_tick)
            hold_reg <= hold_reg + 1'b1;
    end

    assign line_clean = clean_reg;
endmodule // trigger_line_cond

// ### verilog/trigger_exposure_sequencer.sv
// Trigger-driven exposure and readout sequencer with APB registers
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "tes_regs.svh"
module trigger_exposure_sequencer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [`TES_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic input_line_one,
    input wire logic input_line_two,
    input wire logic pulse_gen_in,
    output logic exposure_active,
    output logic readout_active,
    output tes_pkg::seq_state_e seq_state
);
    import tes_pkg::*;

    // Clamp to the legal integration window; a short readout forces the floor
    function automatic logic [23:0] clamp_integ(input logic [23:0] t, input logic [23:0] ro);
        logic [23:0] hi;
        hi = (ro < `TES_MIN_INTEG_US) ? `TES_MIN_INTEG_US : ro;
        if (t < `TES_MIN_INTEG_US)
            clamp_integ = `TES_MIN_INTEG_US;
        else if (t > hi)
            clamp_integ = hi;
        else
            clamp_integ = t;
    endfunction

    cfg_s cfg_reg;
    seq_state_e state_reg;
    seq_state_e state_next;
    logic [`TES_US_CNT_W-1:0] us_cnt_reg;
    logic us_tick_reg;
    logic sw_pulse_reg;
    logic act_d_reg;
    logic fast_reg;
    logic plen_frame_reg;
    logic pexp_reg;
    logic pending_reg;
    logic rd_valid_reg;
    logic discard_reg;
    logic exposure_reg;
    logic readout_reg;
    logic [15:0] frames_left_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic ld_off;
    logic ld_exp;
    logic ld_rd;
    logic exp_done;

    // Microsecond enable from the 250 MHz clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            us_cnt_reg <= '0;
            us_tick_reg <= 1'b0;
        end
        else
        begin
            us_tick_reg <= (us_cnt_reg == `TES_US_CNT_W'(`TES_US_CYCLES - 1));
            us_cnt_reg <= (us_cnt_reg == `TES_US_CNT_W'(`TES_US_CYCLES - 1)) ? '0
                : us_cnt_reg + 1'b1;
        end
    end

    // Both input lines get the same synchroniser and glitch filter
    wire [1:0] line_pins = {input_line_two, input_line_one};
    wire [1:0] line_clean;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_line
            trigger_line_cond #(.WIDTH(16)) u_cond (
                .pclk(pclk),
                .presetn(presetn),
                .us_tick(us_tick_reg),
                .line_pin(line_pins[gi]),
                .reject_width(cfg_reg.glitch_reject_width),
                .line_clean(line_clean[gi])
            );
        end
    endgenerate

    // APB decode; one wait state so every bus output is a flop
    wire apb_access = psel & penable;
    wire addr_hit = (paddr == `TES_CTRL_OFFS) | (paddr == `TES_FRAMES_OFFS)
        | (paddr == `TES_INTEG_OFFS) | (paddr == `TES_READOUT_OFFS)
        | (paddr == `TES_GLITCH_OFFS) | (paddr == `TES_LOCKOUT_OFFS)
        | (paddr == `TES_OFFSET_OFFS) | (paddr == `TES_SWTRIG_OFFS)
        | (paddr == `TES_STATUS_OFFS);
    wire wr_en = apb_access & pready_reg & pwrite & addr_hit;
    wire wr_ctrl = wr_en & (paddr == `TES_CTRL_OFFS);
    wire sw_cmd = wr_en & (paddr == `TES_SWTRIG_OFFS) & pwdata[`TES_SWTRIG_BIT];
    wire discard_clr = wr_en & (paddr == `TES_STATUS_OFFS) & pwdata[`TES_STAT_DISCARD_BIT];

    // Read mux; reserved bits read as zero
    wire [31:0] ctrl_word = {26'h0000000, cfg_reg.exposure_control_select,
        cfg_reg.edge_select, cfg_reg.trigger_origin, cfg_reg.overlap_select,
        cfg_reg.sync_enable};
    wire [31:0] status_word = {frames_left_reg, 10'h000, pending_reg, discard_reg, state_reg};
    wire [31:0] rd_data =
        (paddr == `TES_CTRL_OFFS) ? ctrl_word :
        (paddr == `TES_FRAMES_OFFS) ? {16'h0000, cfg_reg.frames_per_trigger} :
        (paddr == `TES_INTEG_OFFS) ? {8'h00, cfg_reg.integration_time} :
        (paddr == `TES_READOUT_OFFS) ? {8'h00, cfg_reg.frame_period_now} :
        (paddr == `TES_GLITCH_OFFS) ? {16'h0000, cfg_reg.glitch_reject_width} :
        (paddr == `TES_LOCKOUT_OFFS) ? {16'h0000, cfg_reg.lockout_time} :
        (paddr == `TES_OFFSET_OFFS) ? {8'h00, cfg_reg.start_offset_time} :
        (paddr == `TES_STATUS_OFFS) ? status_word : 32'h00000000;

    // Bus handshake and read data capture
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end
        else
        begin
            pready_reg <= apb_access & ~pready_reg;
            pslverr_reg <= apb_access & ~pready_reg & ~addr_hit;
            prdata_reg <= (apb_access & ~pready_reg & ~pwrite) ? rd_data : 32'h00000000;
        end
    end

    // Configuration writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_reg.sync_enable <= 1'b0;
            cfg_reg.overlap_select <= 1'b0;
            cfg_reg.trigger_origin <= ORG_LINE_ONE;
            cfg_reg.edge_select <= 1'b0;
            cfg_reg.exposure_control_select <= 1'b0;
            cfg_reg.frames_per_trigger <= `TES_FRAMES_RESET;
            cfg_reg.integration_time <= `TES_INTEG_RESET;
            cfg_reg.frame_period_now <= `TES_READOUT_RESET;
            cfg_reg.glitch_reject_width <= `TES_GLITCH_RESET;
            cfg_reg.lockout_time <= `TES_LOCKOUT_RESET;
            cfg_reg.start_offset_time <= `TES_OFFSET_RESET;
        end
        else if (wr_ctrl)
        begin
            cfg_reg.sync_enable <= pwdata[`TES_CTRL_SYNC_BIT];
            cfg_reg.overlap_select <= pwdata[`TES_CTRL_OVERLAP_BIT];
            cfg_reg.trigger_origin <= origin_e'(pwdata[`TES_CTRL_ORIGIN_MSB:`TES_CTRL_ORIGIN_LSB]);
            cfg_reg.edge_select <= pwdata[`TES_CTRL_EDGE_BIT];
            cfg_reg.exposure_control_select <= pwdata[`TES_CTRL_EXPSEL_BIT];
        end
        else if (wr_en)
        begin
            if (paddr == `TES_FRAMES_OFFS)
                cfg_reg.frames_per_trigger <= pwdata[`TES_CNT16_MSB:0];
            if (paddr == `TES_INTEG_OFFS)
                cfg_reg.integration_time <= pwdata[`TES_TIME24_MSB:0];
            if (paddr == `TES_READOUT_OFFS)
                cfg_reg.frame_period_now <= pwdata[`TES_TIME24_MSB:0];
            if (paddr == `TES_GLITCH_OFFS)
                cfg_reg.glitch_reject_width <= pwdata[`TES_CNT16_MSB:0];
            if (paddr == `TES_LOCKOUT_OFFS)
                cfg_reg.lockout_time <= pwdata[`TES_CNT16_MSB:0];
            if (paddr == `TES_OFFSET_OFFS)
                cfg_reg.start_offset_time <= (pwdata[`TES_TIME24_MSB:0] > `TES_MAX_OFFSET_US)
                    ? `TES_MAX_OFFSET_US : pwdata[`TES_TIME24_MSB:0];
        end
    end

    // Trigger source, polarity and edge
    wire src_level =
        (cfg_reg.trigger_origin == ORG_LINE_ONE) ? line_clean[0] :
        (cfg_reg.trigger_origin == ORG_LINE_TWO) ? line_clean[1] :
        (cfg_reg.trigger_origin == ORG_PULSE_GEN) ? pulse_gen_in : sw_pulse_reg;
    wire act = src_level ^ cfg_reg.edge_select;
    wire trig_edge = act & ~act_d_reg;
    wire [23:0] integ_eff = clamp_integ(cfg_reg.integration_time,
        cfg_reg.frame_period_now);
    wire [23:0] offset_eff = (cfg_reg.start_offset_time > `TES_MAX_OFFSET_US)
        ? `TES_MAX_OFFSET_US : cfg_reg.start_offset_time;
    wire origin_ok = ~(cfg_reg.exposure_control_select
        & (cfg_reg.trigger_origin == ORG_SOFTWARE));
    wire busy = (state_reg != ST_IDLE);
    wire [15:0] lock_left;
    wire lock_zero;
    wire accept = trig_edge & cfg_reg.sync_enable & ~busy & lock_zero & origin_ok;
    wire discard = trig_edge & cfg_reg.sync_enable & (busy | ~lock_zero);

    // Pulse, edge history, discard flag; set wins; a control write blanks one edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sw_pulse_reg <= 1'b0;
            act_d_reg <= 1'b0;
            discard_reg <= 1'b0;
        end
        else
        begin
            sw_pulse_reg <= sw_cmd;
            act_d_reg <= act | wr_ctrl;
            discard_reg <= discard | (discard_reg & ~discard_clr);
        end
    end

    // Timers
    wire [23:0] off_left;
    wire [23:0] exp_left;
    wire [23:0] rd_left;
    wire off_zero;
    wire exp_zero;
    wire rd_zero;
    us_countdown #(.WIDTH(24)) u_offset (.pclk(pclk), .presetn(presetn),
        .us_tick(us_tick_reg), .load(ld_off), .load_value(offset_eff),
        .remaining(off_left), .zero(off_zero));
    us_countdown #(.WIDTH(24)) u_expose (.pclk(pclk), .presetn(presetn),
        .us_tick(us_tick_reg), .load(ld_exp), .load_value(integ_eff),
        .remaining(exp_left), .zero(exp_zero));
    us_countdown #(.WIDTH(24)) u_readout (.pclk(pclk), .presetn(presetn),
        .us_tick(us_tick_reg), .load(ld_rd), .load_value(cfg_reg.frame_period_now),
        .remaining(rd_left), .zero(rd_zero));
    us_countdown #(.WIDTH(16)) u_lockout (.pclk(pclk), .presetn(presetn),
        .us_tick(us_tick_reg), .load(accept), .load_value(cfg_reg.lockout_time),
        .remaining(lock_left), .zero(lock_zero));

    // Sequencer next state; extra burst frames always use fixed exposure
    wire last_frame = (frames_left_reg == 16'h0001);
    always_comb
    begin
        state_next = state_reg;
        ld_off = 1'b0;
        ld_exp = 1'b0;
        ld_rd = 1'b0;
        exp_done = plen_frame_reg ? ~act : exp_zero;
        unique case (state_reg)
            ST_IDLE:
                if (accept)
                begin
                    state_next = ST_OFFSET;
                    ld_off = 1'b1;
                end
            ST_OFFSET:
                if (off_zero)
                begin
                    state_next = fast_reg ? ST_READ : ST_EXPOSE;
                    ld_rd = fast_reg;
                    ld_exp = ~fast_reg;
                end
            ST_EXPOSE:
                if (exp_done)
                begin
                    state_next = ST_READ;
                    ld_rd = 1'b1;
                end
            ST_READ:
                if (rd_zero)
                begin
                    state_next = last_frame ? ST_IDLE : (fast_reg ? ST_READ : ST_EXPOSE);
                    ld_rd = ~last_frame & fast_reg;
                    ld_exp = ~last_frame & ~fast_reg;
                end
            default:
                state_next = ST_IDLE;
        endcase
    end

    // Fast mode exposure tracking and frames waiting for readout
    wire st_read = (state_reg == ST_READ);
    wire pexp_next = (state_reg == ST_OFFSET && off_zero && fast_reg && plen_frame_reg)
        | (pexp_reg & act);
    wire timed_fast_exp = fast_reg & st_read & ~plen_frame_reg & ~rd_zero
        & (rd_left <= integ_eff);
    wire frame_done = (fast_reg & st_read & rd_zero & ~plen_frame_reg)
        | (pexp_reg & ~pexp_next);
    wire rd_valid_next = ld_rd ? (~fast_reg | pending_reg | frame_done) : rd_valid_reg;
    wire exposure_next = fast_reg ? (timed_fast_exp | pexp_next) : (state_next == ST_EXPOSE);

    // Frame state registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= ST_IDLE;
            fast_reg <= 1'b0;
            plen_frame_reg <= 1'b0;
            frames_left_reg <= `TES_FRAMES_RESET;
            pexp_reg <= 1'b0;
            pending_reg <= 1'b0;
            rd_valid_reg <= 1'b0;
            exposure_reg <= 1'b0;
            readout_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            pexp_reg <= pexp_next;
            rd_valid_reg <= rd_valid_next;
            pending_reg <= (ld_rd & fast_reg) ? 1'b0 : (pending_reg | frame_done);
            exposure_reg <= exposure_next;
            readout_reg <= (state_next == ST_READ) & rd_valid_next;
            if (accept)
            begin
                fast_reg <= cfg_reg.overlap_select;
                plen_frame_reg <= cfg_reg.exposure_control_select;
                frames_left_reg <= (cfg_reg.frames_per_trigger == 16'h0000)
                    ? `TES_FRAMES_RESET : cfg_reg.frames_per_trigger;
            end
            else if (st_read & rd_zero)
            begin
                plen_frame_reg <= 1'b0;
                if (!last_frame)
                    frames_left_reg <= frames_left_reg - 1'b1;
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign exposure_active = exposure_reg;
    assign readout_active = readout_reg;
    assign seq_state = state_reg;

    std_no_overlap_a: assert property (@(posedge pclk) disable iff (!presetn)
        !fast_reg && state_reg != ST_IDLE |-> !(exposure_active && readout_active))
        else $error("exposure and readout overlap in standard mode");
    busy_discard_a: assert property (@(posedge pclk) disable iff (!presetn)
        trig_edge && cfg_reg.sync_enable && busy |=> discard_reg && state_reg != ST_OFFSET)
        else $error("trigger during period not discarded");
    lockout_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        lock_left != 16'h0000 && state_reg == ST_IDLE |=> state_reg == ST_IDLE)
        else $error("trigger accepted inside lockout");
    offset_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        accept |=> state_reg == ST_OFFSET && off_left == offset_eff)
        else $error("offset not started on accepted trigger");
    burst_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg != ST_IDLE |-> frames_left_reg != 16'h0000)
        else $error("burst count reached zero while running");
    integ_window_a: assert property (@(posedge pclk) disable iff (!presetn)
        integ_eff >= `TES_MIN_INTEG_US && (integ_eff <= cfg_reg.frame_period_now
        || integ_eff == `TES_MIN_INTEG_US))
        else $error("integration time outside window");
    pulse_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ST_EXPOSE && plen_frame_reg && !act |=> state_reg == ST_READ
        ##1 !exposure_active)
        else $error("pulse-length exposure did not end with pulse");
    fast_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ST_OFFSET && off_zero && fast_reg |=> state_reg == ST_READ
        && rd_left == cfg_reg.frame_period_now)
        else $error("fast readout not started by trigger");
    fast_place_a: assert property (@(posedge pclk) disable iff (!presetn)
        fast_reg && !plen_frame_reg && st_read && rd_zero |=> !exposure_active
        && $past(exposure_active))
        else $error("fast exposure not ending with readout");
    sw_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        sw_cmd |=> sw_pulse_reg ##1 !sw_pulse_reg)
        else $error("software command did not make one pulse");
endmodule // trigger_exposure_sequencer

// ### test/trig_source.sv
// Behavioural trigger source on the sequencer's input lines
`timescale 1ns/1ps
module trig_source (
    input wire logic pclk,
    output logic line_one,
    output logic line_two,
    output logic pulse_gen
);
    initial
    begin
        line_one = 1'b0;
        line_two = 1'b0;
        pulse_gen = 1'b0;
    end
    // Flip the chosen line after a rising edge
    task automatic flip(input int sel);
        case (sel)
            0: line_one <= ~line_one;
            1: line_two <= ~line_two;
            default: pulse_gen <= ~pulse_gen;
        endcase
    endtask
    // One pulse; callers keep width at 2500 cycles or more
    task automatic fire(input int sel, input int width);
        @(posedge pclk);
        flip(sel);
        repeat (width) @(posedge pclk);
        flip(sel);
    endtask
endmodule // trig_source

// ### test/tb_top.sv
// Self-checking bench for the trigger and exposure sequencer
`timescale 1ns/1ps
`include "tes_regs.svh"
module tb_top;
    import tes_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, line_one, line_two, pulse_gen, exposure_active, readout_active;
    seq_state_e seq_state;
    logic [32:0] expq[$];
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;
    int seed = 32'hA987;

    trigger_exposure_sequencer trigger_exposure_sequencer_inst (.pclk(pclk),
        .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .input_line_one(line_one), .input_line_two(line_two), .pulse_gen_in(pulse_gen),
        .exposure_active(exposure_active), .readout_active(readout_active),
        .seq_state(seq_state));
    trig_source trig_source_inst (.pclk(pclk), .line_one(line_one), .line_two(line_two),
        .pulse_gen(pulse_gen));

    always #2 pclk = ~pclk;

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Setup, access, then wait for pready with no assumed latency
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // Length of the next exposure or readout window; may run up to 1 us short
    task automatic span(input bit ro, input int lo);
        n = 0;
        while ((ro ? readout_active : exposure_active) !== 1'b1)
            @(posedge pclk);
        while ((ro ? readout_active : exposure_active) === 1'b1)
        begin
            @(posedge pclk);
            n++;
        end
        check(ro ? "readout length" : "exposure length", n >= lo - 260 && n <= lo + 10, 1);
    endtask
    task automatic idle_wait();
        while (seq_state !== ST_IDLE)
            @(posedge pclk);
    endtask

    // Read results are taken off the queue in order
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            check("apb read", {pslverr, prdata}, expq.pop_front());
    end
    // Cycle ceiling cuts a hang short
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 95000)
        begin
            n_errors++;
            complete_run();
        end
    end

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`TES_CTRL_OFFS, 33'h0);
        rd(`TES_FRAMES_OFFS, 33'h1);
        rd(`TES_INTEG_OFFS, 33'h3E8);
        rd(`TES_READOUT_OFFS, 33'h7A12);
        rd(`TES_STATUS_OFFS, 33'h0_0001_0001);
        rd(8'h24, 33'h1_0000_0000);
        n = $random(seed) & 32'h7FFFFF;
        apb(1'b1, `TES_OFFSET_OFFS, n);
        rd(`TES_OFFSET_OFFS, n);
        apb(1'b1, `TES_OFFSET_OFFS, 32'hFFFFFF);
        rd(`TES_OFFSET_OFFS, 33'hF42400);
        apb(1'b1, `TES_OFFSET_OFFS, 32'h0);
        $display("test registers done");
        // Integration below the floor, 37 us readout, two-frame burst
        apb(1'b1, `TES_INTEG_OFFS, 32'h5);
        apb(1'b1, `TES_READOUT_OFFS, 32'h25);
        apb(1'b1, `TES_FRAMES_OFFS, 32'h2);
        apb(1'b1, `TES_CTRL_OFFS, 32'h0D);
        apb(1'b1, `TES_SWTRIG_OFFS, 32'h1);
        span(0, 9000);
        span(1, 9250);
        apb(1'b1, `TES_SWTRIG_OFFS, 32'h1);
        span(0, 9000);
        span(1, 9250);
        idle_wait();
        rd(`TES_STATUS_OFFS, 33'h0_0001_0011);
        apb(1'b1, `TES_STATUS_OFFS, 32'h10);
        rd(`TES_STATUS_OFFS, 33'h0_0001_0001);
        $display("test standard burst done");
        apb(1'b1, `TES_FRAMES_OFFS, 32'h1);
        apb(1'b1, `TES_CTRL_OFFS, 32'h21);
        fork
            trig_source_inst.fire(0, 5000);
            span(0, 5000);
        join
        idle_wait();
        apb(1'b1, `TES_CTRL_OFFS, 32'h2D);
        apb(1'b1, `TES_SWTRIG_OFFS, 32'h1);
        repeat (50) @(posedge pclk);
        check("pulse-length software", seq_state, ST_IDLE);
        rd(`TES_STATUS_OFFS, 33'h0_0001_0001);
        $display("test pulse length done");
        // Glitch of 10.4 us against a 20 us reject width
        apb(1'b1, `TES_GLITCH_OFFS, 32'h14);
        apb(1'b1, `TES_CTRL_OFFS, 32'h01);
        trig_source_inst.fire(0, 2600);
        repeat (300) @(posedge pclk);
        check("glitch rejected", seq_state, ST_IDLE);
        apb(1'b1, `TES_GLITCH_OFFS, 32'h0);
        apb(1'b1, `TES_CTRL_OFFS, 32'h15);
        fork
            trig_source_inst.fire(1, 3000);
            begin
                repeat (2900) @(posedge pclk);
                check("rising ignored", seq_state, ST_IDLE);
            end
        join
        span(0, 9000);
        idle_wait();
        $display("test edges done");
        // Fast mode from the pulse generator: 38 us readout, 90 us lockout
        apb(1'b1, `TES_READOUT_OFFS, 32'h26);
        apb(1'b1, `TES_LOCKOUT_OFFS, 32'h5A);
        apb(1'b1, `TES_CTRL_OFFS, 32'h0B);
        fork
            trig_source_inst.fire(2, 2500);
            span(0, 9000);
        join
        idle_wait();
        rd(`TES_STATUS_OFFS, 33'h0_0001_0021);
        trig_source_inst.fire(2, 2500);
        repeat (300) @(posedge pclk);
        check("lockout holds", seq_state, ST_IDLE);
        rd(`TES_STATUS_OFFS, 33'h0_0001_0031);
        $display("test fast and lockout done");
        complete_run();
    end
endmodule // tb_top
